//--- core/fault_pkg.sv
// Purpose: Shared constants, types and helpers for the output voltage fault response block
// Assumes: 40 MHz core clock, same-clock command port from the bus engine
// Notes:   Constants are used as package::name everywhere
package fault_pkg;

  // Command codes
  localparam logic [7:0] CMD_OV_THRESHOLD = 8'h40;
  localparam logic [7:0] CMD_OV_ACTION    = 8'h41;
  localparam logic [7:0] CMD_UV_THRESHOLD = 8'h44;
  localparam logic [7:0] CMD_UV_ACTION    = 8'h45;

  // Values after reset
  localparam logic [7:0]  RST_ACTION       = 8'h80;
  localparam logic [15:0] RST_OV_THRESHOLD = 16'hffff;
  localparam logic [15:0] RST_UV_THRESHOLD = 16'h0000;

  // Action byte fields
  localparam int RESP_HI   = 7;
  localparam int RESP_LO   = 6;
  localparam int RETRY_HI  = 5;
  localparam int RETRY_LO  = 3;
  localparam int TIME_HI   = 2;
  localparam int TIME_LO   = 0;
  localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
  localparam logic [2:0] RETRY_NONE         = 3'h0;
  localparam logic [2:0] RETRY_ENDLESS      = 3'h7;

  // Retry timing
  localparam int CLK_KHZ        = 40000;
  localparam int RETRY_STEP_MS  = 35;
  localparam int STEP_CYCLES    = RETRY_STEP_MS * CLK_KHZ;
  localparam int TIMER_W        = 24;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_WAIT = 2'b01,
    ST_HOLD = 2'b10
  } engine_state_type;

  // Wait in cycles for a retry time field value
  function automatic logic [TIMER_W-1:0] retry_delay(input logic [2:0] code, input int step);
    logic [TIMER_W-1:0] s;
    s = TIMER_W'(step);
    retry_delay = TIMER_W'(({21'h0, code} + 24'h1) * s);
  endfunction

endpackage

//--- core/fault_ctrl_if.sv
// Purpose: Carries one fault channel between the top and its response engine
// Assumes: Single clock domain
// Notes:   One instance per fault kind
`timescale 1ns/10ps
interface fault_ctrl_if;
  logic [7:0] action;
  logic       fault;
  logic       clear;
  logic       enable;
  logic       kill;
  logic       off;
  logic       held;
  logic       status;

  modport engine (input action, fault, clear, enable, kill, output off, held, status);
  modport top    (output action, fault, clear, enable, kill, input off, held, status);
endinterface

//--- core/fault_retry_engine.sv
// Purpose: Shutdown and retry sequencing for one fault kind
// Assumes: Fault level is already synchronous to mclk_in
// Notes:   Step length is a parameter so simulation can shorten it
`timescale 1ns/10ps
module fault_retry_engine #(
  parameter int STEP = fault_pkg::STEP_CYCLES
) (
  input  wire logic  mclk_in,
  input  wire logic  reset_n_in,
  fault_ctrl_if.engine ch
);

  fault_pkg::engine_state_type state;
  logic [fault_pkg::TIMER_W-1:0] timer;
  logic [2:0]                    attempts;
  logic [1:0]                    resp;
  logic [2:0]                    retry;
  logic [2:0]                    rtime;
  logic                          trip;
  logic                          limit_hit;

  assign resp      = ch.action[fault_pkg::RESP_HI:fault_pkg::RESP_LO];
  assign retry     = ch.action[fault_pkg::RETRY_HI:fault_pkg::RETRY_LO];
  assign rtime     = ch.action[fault_pkg::TIME_HI:fault_pkg::TIME_LO];
  // Only a running output can trip; reserved codes only report
  assign trip      = ch.fault && (state == fault_pkg::ST_RUN) && ch.enable
                     && (resp == fault_pkg::RESP_DISABLE_RETRY);
  assign limit_hit = (retry == fault_pkg::RETRY_NONE) || ((retry != fault_pkg::RETRY_ENDLESS) && (attempts >= retry));

  // Sequencer: run, timed wait, latched hold
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      state <= fault_pkg::ST_RUN;
      timer <= '0;
    end else if (ch.clear || !ch.enable) begin
      state <= fault_pkg::ST_RUN;
      timer <= '0;
    end else begin
      unique case (state)
        fault_pkg::ST_RUN: begin
          if (trip) begin
            if (limit_hit || ch.kill) begin
              state <= fault_pkg::ST_HOLD;
            end else begin
              state <= fault_pkg::ST_WAIT;
              timer <= fault_pkg::retry_delay(rtime, STEP);
            end
          end
        end
        fault_pkg::ST_WAIT: begin
          if (ch.kill) begin
            state <= fault_pkg::ST_HOLD;
          end else if (timer <= 24'h000001) begin
            state <= fault_pkg::ST_RUN;
            timer <= '0;
          end else begin
            timer <= timer - 24'h000001;
          end
        end
        fault_pkg::ST_HOLD: state <= fault_pkg::ST_HOLD;
      endcase
    end
  end

  // Attempts counted on each restart; endless mode never saturates the limit
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in || ch.clear || !ch.enable) begin
      attempts <= 3'h0;
    end else if (state == fault_pkg::ST_WAIT && timer <= 24'h000001 && !ch.kill
                 && attempts != 3'h7) begin
      attempts <= attempts + 3'h1;
    end
  end

  // Sticky status: a new fault beats a clear in the same cycle
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      ch.status <= 1'b0;
    end else if (ch.fault) begin
      ch.status <= 1'b1;
    end else if (ch.clear) begin
      ch.status <= 1'b0;
    end
  end

  assign ch.off  = (state != fault_pkg::ST_RUN);
  assign ch.held = (state == fault_pkg::ST_HOLD);

  a_trip_turns_off: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    trip && !ch.clear |=> ch.off)
    else $error("Output not off after trip");
  a_zero_retry_hold: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    trip && !ch.clear && retry == fault_pkg::RETRY_NONE |=> state == fault_pkg::ST_HOLD)
    else $error("Zero retry did not hold");
  a_wait_time_load: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    trip && !ch.clear && !limit_hit && !ch.kill |=> timer == fault_pkg::retry_delay($past(rtime), STEP))
    else $error("Retry wait wrong");
  a_endless_retry: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    trip && !ch.clear && !ch.kill && retry == fault_pkg::RETRY_ENDLESS |=> state == fault_pkg::ST_WAIT)
    else $error("Endless retry stopped");
  a_attempt_bound: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state == fault_pkg::ST_WAIT && retry != fault_pkg::RETRY_ENDLESS |-> attempts < retry)
    else $error("Retry count exceeded");
  a_clear_count: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ch.clear |=> attempts == 3'h0 && !ch.off)
    else $error("Clear did not reset attempts");
  a_status_sticky: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ch.fault |=> ch.status [*1] ##1 (ch.status || $past(ch.clear)))
    else $error("Status bit lost");

endmodule

//--- core/vout_fault_response.sv
// Purpose: Output voltage fault detection, response registers, alert and power good
// Assumes: Command port and voltage samples come from logic on mclk_in
// Notes:   Thresholds and samples share one voltage format, so raw compares are exact
`timescale 1ns/10ps
module vout_fault_response #(
  parameter int STEP_CYCLES = fault_pkg::STEP_CYCLES
) (
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  input  wire logic [7:0]  cmd_in,
  input  wire logic        wr_en_in,
  input  wire logic        wr_word_in,
  input  wire logic [15:0] wr_data_in,
  input  wire logic        rd_en_in,
  input  wire logic        clear_faults_in,
  input  wire logic        output_on_in,
  input  wire logic [15:0] vout_sample_in,
  output logic [15:0]      rd_data_out,
  output logic             rd_valid_out,
  output logic             cmd_error_out,
  output logic             output_enable_out,
  output logic             alert_line_n_out,
  output logic             power_good_output_out,
  output logic             ov_status_out,
  output logic             uv_status_out
);

  logic [7:0]  overvoltage_fault_action;
  logic [7:0]  undervoltage_fault_action;
  logic [15:0] overvoltage_fault_threshold;
  logic [15:0] undervoltage_fault_threshold;
  logic        ov_detect;
  logic        uv_detect;
  logic        byte_ok;
  logic        word_ok;
  logic        known;

  fault_ctrl_if ov_ch ();
  fault_ctrl_if uv_ch ();

  // Decode of which commands are byte and which are word sized
  assign byte_ok = (cmd_in == fault_pkg::CMD_OV_ACTION) || (cmd_in == fault_pkg::CMD_UV_ACTION);
  assign word_ok = (cmd_in == fault_pkg::CMD_OV_THRESHOLD) || (cmd_in == fault_pkg::CMD_UV_THRESHOLD);
  assign known   = byte_ok || word_ok;

  // Register writes; a transfer of the wrong size is dropped
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      overvoltage_fault_action     <= fault_pkg::RST_ACTION;
      undervoltage_fault_action    <= fault_pkg::RST_ACTION;
      overvoltage_fault_threshold  <= fault_pkg::RST_OV_THRESHOLD;
      undervoltage_fault_threshold <= fault_pkg::RST_UV_THRESHOLD;
    end else if (wr_en_in) begin
      if (!wr_word_in && cmd_in == fault_pkg::CMD_OV_ACTION) begin
        overvoltage_fault_action <= wr_data_in[7:0];
      end
      if (!wr_word_in && cmd_in == fault_pkg::CMD_UV_ACTION) begin
        undervoltage_fault_action <= wr_data_in[7:0];
      end
      if (wr_word_in && cmd_in == fault_pkg::CMD_UV_THRESHOLD) begin
        undervoltage_fault_threshold <= wr_data_in;
      end
      if (wr_word_in && cmd_in == fault_pkg::CMD_OV_THRESHOLD) begin
        overvoltage_fault_threshold <= wr_data_in;
      end
    end
  end

  // Read port answers one cycle after the request; bytes sit in the low lane
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      rd_data_out  <= 16'h0000;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in && known;
      if (rd_en_in) begin
        unique case (cmd_in)
          fault_pkg::CMD_OV_ACTION:    rd_data_out <= {8'h00, overvoltage_fault_action};
          fault_pkg::CMD_UV_ACTION:    rd_data_out <= {8'h00, undervoltage_fault_action};
          fault_pkg::CMD_UV_THRESHOLD: rd_data_out <= undervoltage_fault_threshold;
          fault_pkg::CMD_OV_THRESHOLD: rd_data_out <= overvoltage_fault_threshold;
          default:                     rd_data_out <= 16'h0000;
        endcase
      end
    end
  end

  // Unknown command or wrong transfer size flagged for one cycle
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      cmd_error_out <= 1'b0;
    end else begin
      cmd_error_out <= (rd_en_in && !known) ||
                       (wr_en_in && !((byte_ok && !wr_word_in) || (word_ok && wr_word_in)));
    end
  end

  // Same mantissa format on both sides makes the exponent irrelevant to the compare
  assign ov_detect = vout_sample_in > overvoltage_fault_threshold;
  assign uv_detect = output_enable_out && (vout_sample_in < undervoltage_fault_threshold);

  // Channel wiring; a latched hold on either side ends the other's retries
  assign ov_ch.action = overvoltage_fault_action;
  assign ov_ch.fault  = ov_detect;
  assign ov_ch.clear  = clear_faults_in;
  assign ov_ch.enable = output_on_in;
  assign ov_ch.kill   = uv_ch.held;
  assign uv_ch.action = undervoltage_fault_action;
  assign uv_ch.fault  = uv_detect;
  assign uv_ch.clear  = clear_faults_in;
  assign uv_ch.enable = output_on_in;
  assign uv_ch.kill   = ov_ch.held;

  fault_retry_engine #(.STEP(STEP_CYCLES)) ov_engine (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .ch         (ov_ch)
  );

  fault_retry_engine #(.STEP(STEP_CYCLES)) uv_engine (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .ch         (uv_ch)
  );

  // Output state; registered so the pins never glitch on compare ripple
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      output_enable_out     <= 1'b0;
      power_good_output_out <= 1'b0;
    end else begin
      output_enable_out     <= output_on_in && !ov_ch.off && !uv_ch.off;
      power_good_output_out <= output_enable_out && !ov_ch.off && !uv_ch.off &&
                               (vout_sample_in >= undervoltage_fault_threshold);
    end
  end

  // Alert stays low while any sticky bit is set
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      alert_line_n_out <= 1'b1;
      ov_status_out    <= 1'b0;
      uv_status_out    <= 1'b0;
    end else begin
      alert_line_n_out <= !(ov_ch.status || uv_ch.status);
      ov_status_out    <= ov_ch.status;
      uv_status_out    <= uv_ch.status;
    end
  end

  a_byte_action_wr: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    wr_en_in && !wr_word_in && cmd_in == fault_pkg::CMD_OV_ACTION
    |=> overvoltage_fault_action == $past(wr_data_in[7:0]))
    else $error("Overvoltage action not written");
  a_uv_action_wr: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    wr_en_in && !wr_word_in && cmd_in == fault_pkg::CMD_UV_ACTION
    ##1 rd_en_in && cmd_in == fault_pkg::CMD_UV_ACTION && !wr_en_in
    |=> rd_data_out == {8'h00, $past(wr_data_in[7:0], 2)})
    else $error("Undervoltage action readback wrong");
  a_uv_word_wr: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    wr_en_in && wr_word_in && cmd_in == fault_pkg::CMD_UV_THRESHOLD
    |=> undervoltage_fault_threshold == $past(wr_data_in))
    else $error("Undervoltage threshold not written");
  a_pg_drops_low: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    vout_sample_in < undervoltage_fault_threshold |=> !power_good_output_out)
    else $error("Power good held under threshold");
  a_alert_on_fault: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ov_detect |=> ##1 !alert_line_n_out && ov_status_out)
    else $error("Alert not raised on overvoltage");
  a_ov_detect_cmp: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    vout_sample_in > overvoltage_fault_threshold && output_on_in && ov_ch.status == 1'b0
    && overvoltage_fault_action[7:6] == fault_pkg::RESP_DISABLE_RETRY && !clear_faults_in && !ov_ch.off
    |=> ##1 !output_enable_out)
    else $error("Overvoltage did not shut output");

  // Command port: reads answer one edge after the strobe and show the value from before that edge,
  // so a read in the cycle of a write to the same command still returns the old contents
  a_ov_word_wr: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    wr_en_in && wr_word_in && cmd_in == fault_pkg::CMD_OV_THRESHOLD
    |=> overvoltage_fault_threshold == $past(wr_data_in))
    else $error("Overvoltage threshold not written");
  a_ov_word_rd: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    rd_en_in && !wr_en_in && cmd_in == fault_pkg::CMD_OV_THRESHOLD
    |=> rd_valid_out && rd_data_out == $past(overvoltage_fault_threshold))
    else $error("Overvoltage threshold readback wrong");
  a_uv_word_rd: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    rd_en_in && !wr_en_in && cmd_in == fault_pkg::CMD_UV_THRESHOLD
    |=> rd_valid_out && rd_data_out == $past(undervoltage_fault_threshold))
    else $error("Undervoltage threshold readback wrong");
  a_ov_action_rd: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    rd_en_in && !wr_en_in && cmd_in == fault_pkg::CMD_OV_ACTION
    |=> rd_valid_out && rd_data_out == {8'h00, $past(overvoltage_fault_action)})
    else $error("Overvoltage action readback wrong");

  // Refused transfers flag an error and leave every register as it was
  a_size_refused: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    wr_en_in && wr_word_in && cmd_in == fault_pkg::CMD_OV_ACTION
    |=> cmd_error_out && $stable(overvoltage_fault_action))
    else $error("Word write to a byte register not refused");
  a_unknown_read: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    rd_en_in && !known |=> cmd_error_out && !rd_valid_out && rd_data_out == 16'h0000)
    else $error("Unknown read not refused");

  // Undervoltage side of the fault path, mirroring the overvoltage checks; detection needs a
  // running output, so these only fire while the output is enabled
  a_alert_on_uv: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    uv_detect |=> ##1 !alert_line_n_out && uv_status_out)
    else $error("Alert not raised on undervoltage");
  a_uv_shuts_output: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    uv_detect && output_on_in && !clear_faults_in && !uv_ch.off
    && undervoltage_fault_action[fault_pkg::RESP_HI:fault_pkg::RESP_LO] == fault_pkg::RESP_DISABLE_RETRY
    |=> ##1 !output_enable_out)
    else $error("Undervoltage did not shut output");

  // Power good is low in the cycle after any cycle with the output off
  a_pg_needs_output: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !output_enable_out |=> !power_good_output_out)
    else $error("Power good without output");

endmodule

//--- bench/host_model.sv
// Purpose: Host side of the command port, one transfer per access call, a write then a read per write_read call
// Assumes: Requests launch on the falling edge, answers are sampled after the rising edge
// Notes:   Released lines carry inverted values so stale data never looks valid
`timescale 1ns/10ps
module host_model (
  input  wire logic        mclk_in,
  input  wire logic [15:0] rd_data_in,
  input  wire logic        rd_valid_in,
  input  wire logic        cmd_error_in,
  output logic [7:0]       cmd_out,
  output logic             wr_en_out,
  output logic             wr_word_out,
  output logic [15:0]      wr_data_out,
  output logic             rd_en_out
);
  // Idle bus at time zero
  initial begin
    cmd_out     = 8'h00;
    wr_en_out   = 1'b0;
    wr_word_out = 1'b0;
    wr_data_out = 16'h0000;
    rd_en_out   = 1'b0;
  end

  // One strobe cycle; the answer is launched by the edge that takes the strobe; valid and error only last one cycle, read data holds until the next read
  task automatic access(input logic is_rd, input logic word, input logic [7:0] cmd,
                        input logic [15:0] data, output logic [15:0] q, output logic vld, output logic err);
    @(negedge mclk_in);
    cmd_out     = cmd;
    wr_word_out = word;
    wr_data_out = data;
    rd_en_out   = is_rd;
    wr_en_out   = !is_rd;
    @(posedge mclk_in);
    #1;
    q   = rd_data_in;
    vld = rd_valid_in;
    err = cmd_error_in;
    @(negedge mclk_in);
    rd_en_out   = 1'b0;
    wr_en_out   = 1'b0;
    cmd_out     = ~cmd;
    wr_word_out = ~word;
    wr_data_out = ~data;
  endtask

  // Byte write and read of the same command on two adjacent edges
  task automatic write_read(input logic [7:0] cmd, input logic [15:0] data, output logic [15:0] q,
                            output logic vld);
    @(negedge mclk_in);
    cmd_out     = cmd;
    wr_word_out = 1'b0;
    wr_data_out = data;
    wr_en_out   = 1'b1;
    rd_en_out   = 1'b0;
    @(negedge mclk_in);
    wr_en_out   = 1'b0;
    rd_en_out   = 1'b1;
    @(posedge mclk_in);
    #1;
    q   = rd_data_in;
    vld = rd_valid_in;
    @(negedge mclk_in);
    rd_en_out   = 1'b0;
    cmd_out     = ~cmd;
    wr_word_out = 1'b1;
    wr_data_out = ~data;
  endtask
endmodule

//--- bench/testbench.sv
// Purpose: Self-checking bench for the output voltage fault response block
// Assumes: Retry step shortened to STEP cycles
// Notes:   Inputs change on the falling edge, outputs are read just after the rising edge
`timescale 1ns/10ps
module testbench;
  localparam int STEP = 10;
  logic        mclk_in;
  logic        reset_n_in;
  logic [7:0]  cmd;
  logic        wr_en;
  logic        wr_word;
  logic [15:0] wr_data;
  logic        rd_en;
  logic        clear_faults;
  logic        output_on;
  logic [15:0] vout_sample;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic        cmd_error;
  logic        output_enable;
  logic        alert_line_n;
  logic        power_good;
  logic        ov_status;
  logic        uv_status;
  int          miscompares;
  int          checked;

  vout_fault_response #(.STEP_CYCLES(STEP)) dut_u (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .cmd_in(cmd), .wr_en_in(wr_en), .wr_word_in(wr_word),
    .wr_data_in(wr_data), .rd_en_in(rd_en), .clear_faults_in(clear_faults), .output_on_in(output_on),
    .vout_sample_in(vout_sample), .rd_data_out(rd_data), .rd_valid_out(rd_valid), .cmd_error_out(cmd_error),
    .output_enable_out(output_enable), .alert_line_n_out(alert_line_n), .power_good_output_out(power_good),
    .ov_status_out(ov_status), .uv_status_out(uv_status));

  host_model host_u (
    .mclk_in(mclk_in), .rd_data_in(rd_data), .rd_valid_in(rd_valid), .cmd_error_in(cmd_error),
    .cmd_out(cmd), .wr_en_out(wr_en), .wr_word_out(wr_word), .wr_data_out(wr_data), .rd_en_out(rd_en));

  // Clock at 40 MHz
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end

  task automatic report_and_stop;
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] exp, input logic exp_err);
    logic [15:0] q;
    logic        v;
    logic        e;
    host_u.access(1'b1, 1'b0, c, 16'h0000, q, v, e);
    if (!exp_err) chk(q, exp, "read data");
    chk(16'(v), 16'(!exp_err), "read valid");
    chk(16'(e), 16'(exp_err), "read error");
  endtask

  task automatic wr(input logic [7:0] c, input logic word, input logic [15:0] d, input logic exp_err);
    logic [15:0] q;
    logic        v;
    logic        e;
    host_u.access(1'b0, word, c, d, q, v, e);
    chk(16'(e), 16'(exp_err), "write error");
  endtask

  // Clearing with the output request dropped restores the full retry allowance
  task automatic recover;
    @(negedge mclk_in);
    vout_sample  = 16'h4000;
    output_on    = 1'b0;
    clear_faults = 1'b1;
    @(negedge mclk_in);
    output_on    = 1'b1;
    clear_faults = 1'b0;
    cyc(4);
  endtask

  // Counts restarts and the length of the first off period
  task automatic watch(input int n, output int rises, output int low_len);
    logic prev;
    int   run;
    rises   = 0;
    low_len = 0;
    run     = 0;
    prev    = output_enable;
    repeat (n) begin
      cyc(1);
      if (output_enable === 1'b0) run++;
      if (output_enable === 1'b1 && prev === 1'b0) begin
        rises++;
        if (low_len == 0) low_len = run;
      end
      prev = output_enable;
    end
  endtask

  task automatic t_registers;
    logic [15:0] q;
    logic        v;
    rd(fault_pkg::CMD_OV_ACTION, 16'h0080, 1'b0);
    rd(fault_pkg::CMD_UV_ACTION, 16'h0080, 1'b0);
    rd(fault_pkg::CMD_UV_THRESHOLD, 16'h0000, 1'b0);
    wr(fault_pkg::CMD_OV_ACTION, 1'b0, 16'h0091, 1'b0);
    wr(fault_pkg::CMD_OV_ACTION, 1'b1, 16'h0088, 1'b1);
    rd(fault_pkg::CMD_OV_ACTION, 16'h0091, 1'b0);
    wr(fault_pkg::CMD_UV_ACTION, 1'b0, 16'h0082, 1'b0);
    rd(fault_pkg::CMD_UV_ACTION, 16'h0082, 1'b0);
    host_u.write_read(fault_pkg::CMD_UV_ACTION, 16'h0084, q, v);
    chk(q, 16'h0084, "write then read data");
    chk(16'(v), 16'h1, "write then read valid");
    wr(fault_pkg::CMD_UV_THRESHOLD, 1'b0, 16'h0011, 1'b1);
    wr(fault_pkg::CMD_UV_THRESHOLD, 1'b1, 16'hf234, 1'b0);
    rd(fault_pkg::CMD_UV_THRESHOLD, 16'hf234, 1'b0);
    rd(8'h42, 16'h0000, 1'b1);
  endtask

  task automatic t_undervoltage;
    wr(fault_pkg::CMD_UV_THRESHOLD, 1'b1, 16'h2000, 1'b0);
    wr(fault_pkg::CMD_UV_ACTION, 1'b0, 16'h0080, 1'b0);
    recover();
    chk(16'(power_good), 16'h1, "pg high");
    chk(16'(alert_line_n), 16'h1, "alert idle");
    @(negedge mclk_in);
    vout_sample = 16'h1000;
    cyc(2);
    chk(16'(power_good), 16'h0, "pg low");
    cyc(1);
    chk(16'(alert_line_n), 16'h0, "alert low");
    chk({14'h0, ov_status, uv_status}, 16'h1, "uv status");
    chk(16'(output_enable), 16'h0, "uv shutdown");
    @(negedge mclk_in);
    vout_sample = 16'h4000;
    cyc(40);
    chk(16'(output_enable), 16'h0, "held off");
    @(negedge mclk_in);
    clear_faults = 1'b1;
    @(negedge mclk_in);
    clear_faults = 1'b0;
    cyc(4);
    chk({alert_line_n, uv_status, output_enable}, 16'h5, "after clear");
  endtask

  // Every retry time code, with retry counts from one to six
  task automatic t_retry;
    int rises;
    int low_len;
    int r;
    wr(fault_pkg::CMD_OV_THRESHOLD, 1'b1, 16'h8000, 1'b0);
    rd(fault_pkg::CMD_OV_THRESHOLD, 16'h8000, 1'b0);
    for (int t = 0; t < 8; t++) begin
      r = (t % 6) + 1;
      wr(fault_pkg::CMD_OV_ACTION, 1'b0, {8'h00, 2'b10, 3'(r), 3'(t)}, 1'b0);
      @(negedge mclk_in);
      vout_sample = 16'h9000;
      watch((r + 1) * ((t + 1) * STEP + 4) + 10, rises, low_len);
      chk(16'(rises), 16'(r), "restarts");
      chk(16'(low_len >= (t + 1) * STEP && low_len <= (t + 1) * STEP + 2), 16'h1, "wait");
      chk({14'h0, output_enable, ov_status}, 16'h1, "held");
      recover();
    end
    wr(fault_pkg::CMD_OV_ACTION, 1'b0, 16'h00b8, 1'b0);
    @(negedge mclk_in);
    vout_sample = 16'h9000;
    watch(300, rises, low_len);
    chk(16'(rises >= 8), 16'h1, "endless");
    recover();
  endtask

  // Reset in mid-run with a fault pending, then the values after reset
  task automatic t_reset;
    @(negedge mclk_in);
    vout_sample = 16'h9000;
    cyc(3);
    chk(16'(ov_status), 16'h1, "fault before reset");
    @(negedge mclk_in);
    reset_n_in = 1'b0;
    cyc(1);
    chk({11'h0, output_enable, alert_line_n, power_good, ov_status, uv_status}, 16'h0008, "in reset");
    @(negedge mclk_in);
    vout_sample = 16'h4000;
    reset_n_in  = 1'b1;
    rd(fault_pkg::CMD_OV_ACTION, {8'h00, fault_pkg::RST_ACTION}, 1'b0);
    rd(fault_pkg::CMD_OV_THRESHOLD, fault_pkg::RST_OV_THRESHOLD, 1'b0);
    rd(fault_pkg::CMD_UV_THRESHOLD, fault_pkg::RST_UV_THRESHOLD, 1'b0);
  endtask

  initial begin
    miscompares  = 0;
    checked      = 0;
    reset_n_in   = 1'b0;
    clear_faults = 1'b0;
    output_on    = 1'b0;
    vout_sample  = 16'h4000;
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
    reset_n_in = 1'b1;
    t_registers();
    t_undervoltage();
    t_retry();
    t_reset();
    report_and_stop();
  end

  // About 40000 cycles, well past the expected run
  initial begin
    #1000000;
    miscompares++;
    report_and_stop();
  end
endmodule
